// *** otfs_defines.svh ***
// constants for the output terminal function select block
// How it works
// RL1: collector mode resets to switch output
// RL2: collector code resets 0, relay 2
// RL3: code 0 keeps terminal inactive
// RL4: code 1 active while running
// RL5: code 2 active on fault stop
// RL6: code 5 zero speed, off at stop
// RL7: code 6 motor overload pre-warning
// RL8: code 7 drive overload, 10 s ahead
// RL9: codes 8, 9 count values reached
// RL10: code 10 actual length exceeds setting
// RL11: code 11 gives 250 ms pulse per cycle
// RL12: code 12 running time threshold exceeded
// RL13: code 13 frequency limited at limit
// RL14: code 14 torque limit reached, stall
// RL15: code 15 ready for run
// RL16: code 16 voltage input above current input
// RL17: code 17 upper frequency limit reached
// RL18: code 18 lower limit, off at stop
// RL19: code 19 undervoltage state
// RL20: code 20 communication value; 21, 22 reserved
// RL21: code 23 zero frequency, on at stop
// RL22: code 24 power-on time exceeded
// RL23: codes 3,4,25,26 external flags; reserved inactive
// RL24: outputs registered, updated every clock
`ifndef OTFS_DEFINES_SVH
`define OTFS_DEFINES_SVH
`define OTFS_OFS_MODE      32'h0000_0000
`define OTFS_OFS_COLL_FN   32'h0000_0004
`define OTFS_OFS_RELAY_FN  32'h0000_0008
`define OTFS_OFS_COMM      32'h0000_000C
`define OTFS_OFS_STATUS    32'h0000_0010
`define OTFS_RST_MODE      16'h0001
`define OTFS_RST_COLL_FN   16'h0000
`define OTFS_RST_RELAY_FN  16'h0002
`define OTFS_PULSE_MS      250
`define OTFS_CLK_MHZ       200
`define OTFS_PULSE_CYC     (`OTFS_PULSE_MS * 1000 * `OTFS_CLK_MHZ)
`endif

// *** otfs_pkg.sv ***
// types for the output terminal function select block
package otfs_pkg;
  // status conditions fed in by the rest of the drive
  typedef struct packed {
    logic running;        // running with output frequency
    logic fault_stop;     // stopped by fault
    logic freq_level_detect_one;           // freq level detect one
    logic freq_reached;   // frequency reached
    logic zero_freq;      // output frequency zero
    logic motor_ovl_warn; // motor overload pre-warning
    logic drive_ovl_warn; // 10 s ahead of drive overload action
    logic set_count;      // set count value reached
    logic desig_count;    // designated count value reached
    logic length_reached; // actual length over setting
    logic seq_cycle_done; // sequencer cycle done, a level whose rising edge starts the pulse
    logic run_time;       // running time threshold passed
    logic freq_limited;   // frequency limited
    logic torque_limit;   // torque limit / stall
    logic ready;          // ready to run
    logic v_gt_i;         // voltage input above current input
    logic upper_limit;    // at upper frequency limit
    logic lower_limit;    // at lower frequency limit
    logic undervoltage;   // undervoltage state
    logic power_on_time;  // power-on time threshold passed
    logic freq_level_detect_two;           // freq level detect two
    logic freq1_reached;  // frequency 1 reached
  } otfs_status_t;
  typedef enum logic [1:0] {OTFS_IDLE, OTFS_PULSE} otfs_pulse_state_t;
endpackage

// *** otfs_term_model.sv ***
// model of the external load on one output terminal
`timescale 1ns/1ps
`default_nettype none
module otfs_term_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        term,
  output logic [31:0]      rises,
  output logic [31:0]      width
);
  logic [31:0] run_len;  // cycles seen high so far
  logic        term_q;   // previous level, for edge finding
  // the load only listens; it never drives the terminal back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= 32'h0;
      term_q  <= 1'b0;
      rises   <= 32'h0;
      width   <= 32'h0;
    end else begin
      term_q <= term;
      // count activations
      if (term && !term_q) begin
        rises <= rises + 32'h1;
      end
      // width latched on the falling level
      if (term) begin
        run_len <= run_len + 32'h1;
      end else begin
        run_len <= 32'h0;
        if (term_q) begin
          width <= run_len;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** otfs_top.sv ***
// output terminal function select with ahb-lite register access
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "otfs_defines.svh"
module otfs_top
  import otfs_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `OTFS_PULSE_CYC  // 250 ms pulse, shorten in sim
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire otfs_status_t status_in,
  output logic              open_collector_output,
  output logic              relay_output
);
  // bus capture of the address phase
  logic        wr_pend;   // write data phase pending
  logic [7:0]  wr_addr;   // latched write address
  logic [15:0] collector_output_mode;
  logic [15:0] collector_function_code;
  logic [15:0] relay_function_code;
  logic [1:0]  comm_value;   // comm-written levels: bit0 collector, bit1 relay
  otfs_status_t st;          // synchronised status
  otfs_status_t st_meta;     // first synchroniser stage
  otfs_pulse_state_t pstate; // pulse machine state
  logic [31:0] pcount;       // pulse cycles remaining
  logic        done_q;       // previous cycle-done level
  logic        pulse;        // 250 ms pulse active
  logic        next_coll;
  logic        next_relay;

  // every access is single cycle, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // register writes; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      collector_output_mode   <= `OTFS_RST_MODE;     // RL1
      collector_function_code <= `OTFS_RST_COLL_FN;  // RL2
      relay_function_code     <= `OTFS_RST_RELAY_FN; // RL2
      comm_value              <= 2'h0;
    end else if (wr_pend) begin
      case ({24'h00_0000, wr_addr})
        `OTFS_OFS_MODE:     collector_output_mode   <= hwdata[15:0];
        `OTFS_OFS_COLL_FN:  collector_function_code <= hwdata[15:0];
        `OTFS_OFS_RELAY_FN: relay_function_code     <= hwdata[15:0];
        `OTFS_OFS_COMM:     comm_value              <= hwdata[1:0]; // RL20
        default: ;
      endcase
    end
  end

  // read data registered at the address phase, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case ({24'h00_0000, haddr[7:0]})
        `OTFS_OFS_MODE:     hrdata <= {16'h0000, collector_output_mode};
        `OTFS_OFS_COLL_FN:  hrdata <= {16'h0000, collector_function_code};
        `OTFS_OFS_RELAY_FN: hrdata <= {16'h0000, relay_function_code};
        `OTFS_OFS_COMM:     hrdata <= {30'h0000_0000, comm_value};
        `OTFS_OFS_STATUS:   hrdata <= {29'h0000_0000, pulse, relay_output, open_collector_output};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // status comes from other logic on pins: two flops first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_meta <= '0;
      st      <= '0;
    end else begin
      st_meta <= status_in;
      st      <= st_meta;
    end
  end

  // sequencer cycle done edge starts a fixed 250 ms pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      pstate <= OTFS_IDLE;
      pcount <= 32'h0000_0000;
    end else begin
      done_q <= st.seq_cycle_done;
      case (pstate)
        OTFS_IDLE: begin
          if (st.seq_cycle_done && !done_q) begin
            pstate <= OTFS_PULSE; // RL11
            pcount <= PULSE_CYC - 1;
          end
        end
        OTFS_PULSE: begin
          if (pcount == 32'h0000_0000) pstate <= OTFS_IDLE;
          else pcount <= pcount - 32'h0000_0001; // RL11
        end
        default: pstate <= OTFS_IDLE;
      endcase
    end
  end
  assign pulse = (pstate == OTFS_PULSE);

  // map one function code onto its status condition
  function automatic logic sel_fn(input logic [15:0] code, input otfs_status_t s,
                                  input logic p, input logic comm);
    case (code)
      16'h0000: sel_fn = 1'b0;                          // RL3
      16'h0001: sel_fn = s.running;                     // RL4
      16'h0002: sel_fn = s.fault_stop;                  // RL5
      16'h0003: sel_fn = s.freq_level_detect_one;                        // RL23
      16'h0004: sel_fn = s.freq_reached;                // RL23
      16'h0005: sel_fn = s.running && s.zero_freq;      // RL6
      16'h0006: sel_fn = s.motor_ovl_warn;              // RL7
      16'h0007: sel_fn = s.drive_ovl_warn;              // RL8
      16'h0008: sel_fn = s.set_count;                   // RL9
      16'h0009: sel_fn = s.desig_count;                 // RL9
      16'h000A: sel_fn = s.length_reached;              // RL10
      16'h000B: sel_fn = p;                             // RL11
      16'h000C: sel_fn = s.run_time;                    // RL12
      16'h000D: sel_fn = s.freq_limited;                // RL13
      16'h000E: sel_fn = s.torque_limit;                // RL14
      16'h000F: sel_fn = s.ready && !s.fault_stop;      // RL15
      16'h0010: sel_fn = s.v_gt_i;                      // RL16
      16'h0011: sel_fn = s.upper_limit;                 // RL17
      16'h0012: sel_fn = s.running && s.lower_limit;    // RL18
      16'h0013: sel_fn = s.undervoltage;                // RL19
      16'h0014: sel_fn = comm;                          // RL20
      16'h0017: sel_fn = s.zero_freq || !s.running;     // RL21
      16'h0018: sel_fn = s.power_on_time;               // RL22
      16'h0019: sel_fn = s.freq_level_detect_two;                        // RL23
      16'h001A: sel_fn = s.freq1_reached;               // RL23
      default:  sel_fn = 1'b0;                          // RL23
    endcase
  endfunction

  // selection; collector only switches when in switch-signal mode
  always_comb begin
    next_coll  = (collector_output_mode == `OTFS_RST_MODE) &&
                 sel_fn(collector_function_code, st, pulse, comm_value[0]);
    next_relay = sel_fn(relay_function_code, st, pulse, comm_value[1]);
  end

  // terminals registered every clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_collector_output <= 1'b0;
      relay_output          <= 1'b0;
    end else begin
      open_collector_output <= next_coll;  // RL24
      relay_output          <= next_relay; // RL24
    end
  end

  // pulse start sequence
  sequence s_done_rise;
    st.seq_cycle_done && !done_q && pstate == OTFS_IDLE;
  endsequence
  property p_pulse_start;
    @(posedge hclk) disable iff (!hresetn) s_done_rise |=> pulse;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not started"); // RL11
  property p_pulse_hold;
    @(posedge hclk) disable iff (!hresetn) $rose(pulse) |-> pulse [*8];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse too short"); // RL11
  property p_code0;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0000 |=> !relay_output;
  endproperty
  a_code0: assert property (p_code0) else $error("code 0 drove relay"); // RL3
  property p_code1;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0001 |=> relay_output == $past(st.running);
  endproperty
  a_code1: assert property (p_code1) else $error("code 1 mismatch"); // RL4
  property p_code2;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0002 |=> relay_output == $past(st.fault_stop);
  endproperty
  a_code2: assert property (p_code2) else $error("code 2 mismatch"); // RL5
  property p_code5;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0005 && !st.running |=> !relay_output;
  endproperty
  a_code5: assert property (p_code5) else $error("code 5 on at stop"); // RL6
  property p_code18;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0012 && !st.running |=> !relay_output;
  endproperty
  a_code18: assert property (p_code18) else $error("code 18 on at stop"); // RL18
  property p_code23;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0017 && !st.running |=> relay_output;
  endproperty
  a_code23: assert property (p_code23) else $error("code 23 off at stop"); // RL21
  property p_reserved;
    @(posedge hclk) disable iff (!hresetn) relay_function_code == 16'h0015 |=> !relay_output;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drove relay"); // RL23
  property p_coll_sel;
    @(posedge hclk) disable iff (!hresetn)
      collector_output_mode == 16'h0001 && collector_function_code == 16'h0013
      |=> open_collector_output == $past(st.undervoltage);
  endproperty
  a_coll_sel: assert property (p_coll_sel) else $error("collector selection wrong"); // RL19
  // collector follows the chosen condition only in switch mode
  property p_mode_off;
    @(posedge hclk) disable iff (!hresetn) collector_output_mode != 16'h0001 |=> !open_collector_output;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("collector on outside switch mode"); // RL1
  property p_coll_code0;
    @(posedge hclk) disable iff (!hresetn) collector_function_code == 16'h0000 |=> !open_collector_output;
  endproperty
  a_coll_code0: assert property (p_coll_code0) else $error("code 0 drove collector"); // RL3

  // plain codes: relay follows one flag, one edge late (output flop)
  property p_code3;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0003 |=> relay_output == $past(st.freq_level_detect_one);
  endproperty
  a_code3: assert property (p_code3) else $error("code 3 mismatch"); // RL23
  property p_code6;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0006 |=> relay_output == $past(st.motor_ovl_warn);
  endproperty
  a_code6: assert property (p_code6) else $error("code 6 mismatch"); // RL7
  property p_code7;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0007 |=> relay_output == $past(st.drive_ovl_warn);
  endproperty
  a_code7: assert property (p_code7) else $error("code 7 mismatch"); // RL8
  property p_code8;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0008 |=> relay_output == $past(st.set_count);
  endproperty
  a_code8: assert property (p_code8) else $error("code 8 mismatch"); // RL9
  property p_code9;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0009 |=> relay_output == $past(st.desig_count);
  endproperty
  a_code9: assert property (p_code9) else $error("code 9 mismatch"); // RL9
  property p_code10;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000A |=> relay_output == $past(st.length_reached);
  endproperty
  a_code10: assert property (p_code10) else $error("code 10 mismatch"); // RL10
  property p_code12;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000C |=> relay_output == $past(st.run_time);
  endproperty
  a_code12: assert property (p_code12) else $error("code 12 mismatch"); // RL12
  property p_code13;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000D |=> relay_output == $past(st.freq_limited);
  endproperty
  a_code13: assert property (p_code13) else $error("code 13 mismatch"); // RL13
  property p_code14;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000E |=> relay_output == $past(st.torque_limit);
  endproperty
  a_code14: assert property (p_code14) else $error("code 14 mismatch"); // RL14
  property p_code16;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0010 |=> relay_output == $past(st.v_gt_i);
  endproperty
  a_code16: assert property (p_code16) else $error("code 16 mismatch"); // RL16
  property p_code17;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0011 |=> relay_output == $past(st.upper_limit);
  endproperty
  a_code17: assert property (p_code17) else $error("code 17 mismatch"); // RL17
  property p_code19;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0013 |=> relay_output == $past(st.undervoltage);
  endproperty
  a_code19: assert property (p_code19) else $error("code 19 mismatch"); // RL19
  property p_code24;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0018 |=> relay_output == $past(st.power_on_time);
  endproperty
  a_code24: assert property (p_code24) else $error("code 24 mismatch"); // RL22

  // combined codes: the active side of codes 5, 18 and 23, code 15 in full, then comm code 20 and pulse code 11
  property p_code5_on;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0005 && st.running && st.zero_freq |=> relay_output;
  endproperty
  a_code5_on: assert property (p_code5_on) else $error("code 5 off at zero speed"); // RL6
  property p_code15;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000F |=> relay_output == $past(st.ready && !st.fault_stop);
  endproperty
  a_code15: assert property (p_code15) else $error("code 15 mismatch"); // RL15
  property p_code18_on;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0012 && st.running && st.lower_limit |=> relay_output;
  endproperty
  a_code18_on: assert property (p_code18_on) else $error("code 18 off at lower limit"); // RL18
  property p_code23_on;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0017 && st.zero_freq |=> relay_output;
  endproperty
  a_code23_on: assert property (p_code23_on) else $error("code 23 off at zero speed"); // RL21
  property p_code20;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h0014 |=> relay_output == $past(comm_value[1]);
  endproperty
  a_code20: assert property (p_code20) else $error("code 20 mismatch"); // RL20
  property p_code11;
    @(posedge hclk) disable iff (!hresetn)
      relay_function_code == 16'h000B |=> relay_output == $past(pulse);
  endproperty
  a_code11: assert property (p_code11) else $error("code 11 mismatch"); // RL11

  // helper: cycles the pulse has stood; too long for a repetition count
  logic [31:0] pulse_len;  // holds the width one cycle after each pulse, then zero until the next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_len <= 32'h0000_0000;
    end else if (pulse) begin
      pulse_len <= pulse_len + 32'h0000_0001;
    end else begin
      pulse_len <= 32'h0000_0000;
    end
  end
  property p_pulse_width;
    @(posedge hclk) disable iff (!hresetn) $fell(pulse) |-> pulse_len == PULSE_CYC;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong"); // RL11
  // last counted cycle of the pulse
  sequence s_pulse_last;
    pulse && pcount == 32'h0000_0000;
  endsequence
  property p_pulse_end;
    @(posedge hclk) disable iff (!hresetn) s_pulse_last |=> !pulse;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse overran its count"); // RL11
endmodule
`default_nettype wire

// *** output_terminal_function_select_bench.sv ***
// self-checking bench for the output terminal function select block
`timescale 1ns/1ps
`default_nettype none
`include "otfs_defines.svh"
module output_terminal_function_select_bench
  import otfs_pkg::*;
;
  localparam int PULSE = 20;  // short pulse so the run stays brief
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  wire logic    hready;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  otfs_status_t status_in;
  logic         open_collector_output;
  logic         relay_output;
  logic [31:0]  rises_oc;
  logic [31:0]  width_oc;
  logic [31:0]  rises_rl;
  logic [31:0]  width_rl;
  int           mismatches;
  int           n_checks;
  assign hready = hreadyout;  // single slave drives the bus ready
  otfs_top #(.PULSE_CYC(PULSE)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .status_in(status_in),
    .open_collector_output(open_collector_output), .relay_output(relay_output));
  otfs_term_model load_oc (.clk(hclk), .rst_n(hresetn), .term(open_collector_output), .rises(rises_oc),
    .width(width_oc));
  otfs_term_model load_rl (.clk(hclk), .rst_n(hresetn), .term(relay_output), .rises(rises_rl),
    .width(width_rl));
  // free running clock
  always #2.5 hclk = ~hclk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one single word transfer; waits on ready in both phases
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // new status, then wait past the sync and output flops
  task settle(input logic [21:0] v);
    @(posedge hclk);
    status_in <= otfs_status_t'(v);
    repeat (4) @(posedge hclk);
    #1;
  endtask
  task t_regs;
    logic [31:0] r;
    xfer(1'b0, `OTFS_OFS_MODE, 32'h0, r);
    check(r, 32'h0000_0001);
    check({31'h0, hresp}, 32'h0);
    xfer(1'b0, `OTFS_OFS_COLL_FN, 32'h0, r);
    check(r, 32'h0000_0000);
    xfer(1'b0, `OTFS_OFS_RELAY_FN, 32'h0, r);
    check(r, 32'h0000_0002);
    xfer(1'b1, `OTFS_OFS_RELAY_FN, 32'hABCD_001A, r);
    xfer(1'b0, `OTFS_OFS_RELAY_FN, 32'h0, r);
    check(r, 32'h0000_001A);
    xfer(1'b1, 32'h0000_0020, 32'hFFFF_FFFF, r);
    xfer(1'b0, 32'h0000_0020, 32'h0, r);
    check(r, 32'h0000_0000);
    $display("test regs done");
  endtask
  // stimulus that should turn a code on, one that should not, and the on level
  function automatic void vecs(input int c, output logic [21:0] on, output logic [21:0] off, output logic e);
    int b;
    b = (c <= 19) ? 22 - c : 26 - c;
    on = 22'h0;
    off = 22'h0;
    e = 1'b1;
    if (c inside {0, 21, 22, 27}) begin
      on = 22'h3F_FFFF;  // everything set, still quiet
      e = 1'b0;
    end else if (c == 23) begin
      off = 22'h20_0000;  // running at speed; stopped must light it
    end else begin
      on[b] = 1'b1;
      if (c == 5 || c == 18) begin
        off = on;  // flag alone while stopped
        on[21] = 1'b1;
      end
      if (c == 15) off = on | 22'h10_0000;
    end
  endfunction
  task t_sweep;
    logic [31:0] r;
    logic [21:0] on;
    logic [21:0] off;
    logic        e;
    for (int c = 0; c < 28; c++) begin
      if (c != 11 && c != 20) begin
        xfer(1'b1, `OTFS_OFS_COLL_FN, 32'(c), r);
        xfer(1'b1, `OTFS_OFS_RELAY_FN, 32'(c), r);
        vecs(c, on, off, e);
        settle(on);
        check({31'h0, open_collector_output}, {31'h0, e});
        check({31'h0, relay_output}, {31'h0, e});
        settle(off);
        check({31'h0, open_collector_output}, 32'h0);
        check({31'h0, relay_output}, 32'h0);
      end
    end
    $display("test sweep done");
  endtask
  task t_comm_mode;
    logic [31:0] r;
    xfer(1'b1, `OTFS_OFS_COLL_FN, 32'd20, r);
    xfer(1'b1, `OTFS_OFS_RELAY_FN, 32'd20, r);
    for (int i = 1; i < 3; i++) begin
      xfer(1'b1, `OTFS_OFS_COMM, 32'(i), r);
      settle(22'h0);
      check({31'h0, open_collector_output}, 32'(i == 1));
      check({31'h0, relay_output}, 32'(i == 2));
    end
    xfer(1'b1, `OTFS_OFS_COLL_FN, 32'd1, r);
    xfer(1'b1, `OTFS_OFS_MODE, 32'h0, r);
    settle(22'h20_0000);
    check({31'h0, open_collector_output}, 32'h0);
    xfer(1'b1, `OTFS_OFS_MODE, 32'h1, r);
    settle(22'h20_0000);
    check({31'h0, open_collector_output}, 32'h1);
    xfer(1'b0, `OTFS_OFS_STATUS, 32'h0, r);
    check(r, 32'h0000_0003);
    $display("test comm and mode done");
  endtask
  task t_pulse;
    logic [31:0] r;
    logic [31:0] n_oc;
    logic [31:0] n_rl;
    xfer(1'b1, `OTFS_OFS_COLL_FN, 32'd11, r);
    xfer(1'b1, `OTFS_OFS_RELAY_FN, 32'd11, r);
    settle(22'h0);
    n_oc = rises_oc;
    n_rl = rises_rl;
    settle(22'h00_0800);  // held far longer than the pulse
    repeat (30) @(posedge hclk);
    settle(22'h0);
    repeat (30) @(posedge hclk);
    #1;
    check(rises_oc - n_oc, 32'h1);
    check(width_oc, 32'(PULSE));
    check(rises_rl - n_rl, 32'h1);
    check(width_rl, 32'(PULSE));
    $display("test pulse done");
  endtask
  // cut a hang short
  initial begin
    #50000;
    mismatches++;
    summarize;
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    status_in = otfs_status_t'(22'h0);
    mismatches = 0;
    n_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_sweep;
    t_comm_mode;
    t_pulse;
    summarize;
  end
endmodule
`default_nettype wire
